// file: src/hpt_device.sv
`timescale 1ns/10ps
module hpt_device (
    // clock and reset
    input  wire logic                         mclk_i,
    input  wire logic                         nrst_i,
    // host pins
    hpt_if.dev                                hp,
    // strap
    input  wire logic                         host_width_strap_i,
    // dma bus to on-chip memory
    output logic                              dma_req_o,
    output logic                              dma_we_o,
    output logic [hpt_pkg::ADDR_W-1:0]        dma_addr_o,
    output logic [hpt_pkg::DATA_W-1:0]        dma_wdata_o,
    input  wire logic                         dma_ack_i,
    input  wire logic [hpt_pkg::DATA_W-1:0]   dma_rdata_i,
    // dsp memory access contention
    input  wire logic                         dsp_req_i,
    input  wire logic [hpt_pkg::ADDR_W-1:0]   dsp_addr_i,
    output logic                              dsp_stall_o,
    // dsp side control register
    input  wire logic                         ctl_wr_i,
    input  wire logic [hpt_pkg::DATA_W-1:0]   ctl_wdata_i,
    output logic [hpt_pkg::DATA_W-1:0]        ctl_o,
    // bank-switch control register keeper bits
    input  wire logic                         bank_switch_control_reg_wr_i,
    input  wire logic [hpt_pkg::DATA_W-1:0]   bank_switch_control_reg_wdata_i,
    output logic [hpt_pkg::DATA_W-1:0]        bank_switch_control_reg_o,
    // keeper status
    output logic                              data_keep_on_o,
    output logic                              addr_keep_on_o,
    output logic                              wide_mode_o
);
    // ========================================
    // pin synchronisers
    logic [hpt_pkg::SYNC_W-1:0] s1_ff;
    logic [hpt_pkg::SYNC_W-1:0] s2_ff;
    logic [hpt_pkg::SYNC_W-1:0] s3_ff;
    logic [hpt_pkg::SYNC_W-1:0] filt_ff;
    logic [hpt_pkg::SYNC_W-1:0] pins;
    logic [hpt_pkg::SYNC_W-1:0] nxt_filt;

    assign pins = {host_width_strap_i, hp.host_chip_select_n,
                   hp.host_data_strobe_one_n, hp.host_data_strobe_two_n,
                   hp.host_read_write, hp.byte_half_select,
                   hp.host_register_select};

    genvar gi;
    generate
        for (gi = 0; gi < hpt_pkg::SYNC_W; gi++) begin : g_flt
            assign nxt_filt[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi]
                                                           : filt_ff[gi];
        end
    endgenerate

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_ff   <= hpt_pkg::SYNC_RST;
            s2_ff   <= hpt_pkg::SYNC_RST;
            s3_ff   <= hpt_pkg::SYNC_RST;
            filt_ff <= hpt_pkg::SYNC_RST;
        end else begin
            s1_ff   <= pins;
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            filt_ff <= nxt_filt;
        end
    end

    // ========================================
    // decoded pin state
    logic       wide;
    logic       act;
    logic       rd;
    logic       half_low;
    logic [1:0] sel;

    assign wide     = filt_ff[hpt_pkg::SY_STRAP];
    assign act      = !filt_ff[hpt_pkg::SY_CS] && !filt_ff[hpt_pkg::SY_DS1]
                      && !filt_ff[hpt_pkg::SY_DS2];
    assign rd       = filt_ff[hpt_pkg::SY_RW];
    assign half_low = filt_ff[hpt_pkg::SY_BIL] == hpt_pkg::HALF_LOW;
    assign sel      = filt_ff[1:0];

    function automatic logic [7:0] pick(input logic [15:0] w,
                                        input logic        lo);
        pick = lo ? w[7:0] : w[15:8];
    endfunction

    function automatic logic [15:0] put(input logic [15:0] w,
                                        input logic        lo,
                                        input logic [7:0]  b);
        put = lo ? {w[15:8], b} : {b, w[7:0]};
    endfunction

    // ========================================
    // access state machine
    hpt_pkg::hpt_dev_state_t st_ff;
    hpt_pkg::hpt_dev_state_t nxt_st;
    logic [15:0] addr_ff;
    logic [15:0] data_ff;
    logic [15:0] ctrl_ff;
    logic [15:0] out_ff;
    logic        we_ff;
    logic        inc_ff;
    logic [15:0] hd_in;
    logic [7:0]  hb;
    logic [15:0] addr_nxt;
    logic        is_data;

    assign hd_in    = hp.host_data_bus;
    assign hb       = hd_in[7:0];
    assign addr_nxt = addr_ff + hpt_pkg::ADDR_INC;
    assign is_data  = (sel == hpt_pkg::SEL_DATA)
                      || (sel == hpt_pkg::SEL_DATA_INC);

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            hpt_pkg::DS_IDLE: begin
                if (act) begin
                    if (wide) begin
                        nxt_st = hpt_pkg::DS_DMA;
                    end else if (is_data && (rd != half_low)) begin
                        nxt_st = hpt_pkg::DS_DMA;
                    end else begin
                        nxt_st = hpt_pkg::DS_DONE;
                    end
                end
            end
            hpt_pkg::DS_DMA: begin
                if (dma_ack_i) begin
                    nxt_st = hpt_pkg::DS_DONE;
                end
            end
            hpt_pkg::DS_DONE: begin
                if (!act) begin
                    nxt_st = hpt_pkg::DS_IDLE;
                end
            end
            default: nxt_st = hpt_pkg::DS_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff   <= hpt_pkg::DS_IDLE;
            addr_ff <= hpt_pkg::WORD_ZERO;
            data_ff <= hpt_pkg::WORD_ZERO;
            ctrl_ff <= hpt_pkg::WORD_ZERO;
            out_ff  <= hpt_pkg::WORD_ZERO;
            we_ff   <= 1'b0;
            inc_ff  <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            if (st_ff == hpt_pkg::DS_IDLE && act && wide) begin
                addr_ff <= hp.host_address_bus;
                we_ff   <= !rd;
                inc_ff  <= 1'b0;
                if (!rd) begin
                    data_ff <= hd_in;
                end
            end else if (st_ff == hpt_pkg::DS_IDLE && act) begin
                we_ff  <= !rd;
                inc_ff <= sel == hpt_pkg::SEL_DATA_INC;
                case (sel)
                    hpt_pkg::SEL_CTRL: begin
                        if (rd) begin
                            out_ff <= {8'h00, pick(ctrl_ff, half_low)};
                        end else begin
                            ctrl_ff <= put(ctrl_ff, half_low, hb);
                        end
                    end
                    hpt_pkg::SEL_ADDR: begin
                        if (rd) begin
                            out_ff <= {8'h00, pick(addr_ff, half_low)};
                        end else begin
                            addr_ff <= put(addr_ff, half_low, hb);
                        end
                    end
                    default: begin
                        if (rd && half_low) begin
                            out_ff <= {8'h00, data_ff[7:0]};
                            if (sel == hpt_pkg::SEL_DATA_INC) begin
                                addr_ff <= addr_nxt;
                            end
                        end else if (!rd) begin
                            data_ff <= put(data_ff, half_low, hb);
                        end
                    end
                endcase
            end else if (st_ff == hpt_pkg::DS_DMA && dma_ack_i) begin
                if (!we_ff) begin
                    data_ff <= dma_rdata_i;
                    out_ff  <= wide ? dma_rdata_i
                                    : {8'h00, dma_rdata_i[15:8]};
                end else if (inc_ff) begin
                    addr_ff <= addr_nxt;
                end
            end else if (ctl_wr_i && !wide) begin
                ctrl_ff <= ctl_wdata_i;
            end
        end
    end

    // dma runs independent of cpu halt state
    assign dma_req_o   = st_ff == hpt_pkg::DS_DMA;
    assign dma_we_o    = we_ff;
    assign dma_addr_o  = addr_ff[hpt_pkg::ADDR_W-1:0];
    assign dma_wdata_o = data_ff;
    // host wins a same-address clash
    assign dsp_stall_o = dsp_req_i && dma_req_o
                         && (dsp_addr_i == dma_addr_o);
    // no register select in wide mode
    assign ctl_o       = wide ? hpt_pkg::WORD_ZERO : ctrl_ff;

    assign hp.hd_dev_out     = out_ff;
    // release the bus as soon as the raw strobes lift
    assign hp.hd_dev_oe_n    = !(st_ff == hpt_pkg::DS_DONE && rd && act
                                 && !hp.host_chip_select_n
                                 && !hp.host_data_strobe_one_n
                                 && !hp.host_data_strobe_two_n);
    assign hp.host_ready_out = st_ff == hpt_pkg::DS_DONE;

    // ========================================
    // bus keepers
    logic        bh_ff;
    logic        hbh_ff;
    logic [15:0] keep_ff;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {hbh_ff, bh_ff} <= hpt_pkg::BANK_SWITCH_CONTROL_REG_KEEP_RST;
            keep_ff         <= hpt_pkg::WORD_ZERO;
        end else begin
            if (bank_switch_control_reg_wr_i) begin
                bh_ff  <= bank_switch_control_reg_wdata_i[hpt_pkg::BANK_SWITCH_CONTROL_REG_DATA_KEEP_BIT];
                hbh_ff <= bank_switch_control_reg_wdata_i[hpt_pkg::BANK_SWITCH_CONTROL_REG_HOST_KEEP_BIT];
            end
            if (!hp.hd_dev_oe_n || !hp.hd_host_oe_n) begin
                keep_ff <= hd_in;
            end
        end
    end

    always_comb begin
        bank_switch_control_reg_o = hpt_pkg::WORD_ZERO;
        bank_switch_control_reg_o[hpt_pkg::BANK_SWITCH_CONTROL_REG_DATA_KEEP_BIT] = bh_ff;
        bank_switch_control_reg_o[hpt_pkg::BANK_SWITCH_CONTROL_REG_HOST_KEEP_BIT] = hbh_ff;
    end

    assign hp.hd_keep_val = keep_ff;
    assign hp.hd_keep_on  = wide || hbh_ff;
    assign data_keep_on_o = bh_ff;
    assign addr_keep_on_o = wide && hbh_ff;
    assign wide_mode_o    = wide;
endmodule

// file: src/hpt_pkg.sv
package hpt_pkg;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 15;
    localparam int PIN_W  = 16;

    // register select codes, 8-bit mode
    localparam logic [1:0] SEL_CTRL     = 2'h0;
    localparam logic [1:0] SEL_DATA_INC = 2'h1;
    localparam logic [1:0] SEL_ADDR     = 2'h2;
    localparam logic [1:0] SEL_DATA     = 2'h3;

    // byte half select: first transfer carries the high byte
    localparam logic HALF_HIGH = 1'b0;
    localparam logic HALF_LOW  = 1'b1;

    // bank-switch control register layout
    localparam int         BANK_SWITCH_CONTROL_REG_DATA_KEEP_BIT = 1;
    localparam int         BANK_SWITCH_CONTROL_REG_HOST_KEEP_BIT = 2;
    localparam logic [1:0] BANK_SWITCH_CONTROL_REG_KEEP_RST      = 2'h0;

    // synchronised pin vector: strap,cs_n,ds1_n,ds2_n,rw,bil,sel[1:0]
    localparam int         SYNC_W     = 8;
    localparam int         SY_STRAP   = 7;
    localparam int         SY_CS      = 6;
    localparam int         SY_DS1     = 5;
    localparam int         SY_DS2     = 4;
    localparam int         SY_RW      = 3;
    localparam int         SY_BIL     = 2;
    localparam logic [7:0] SYNC_RST   = 8'h78;

    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] ADDR_INC  = 16'h0001;

    typedef enum logic [1:0] {
        DS_IDLE = 2'b00,
        DS_DMA  = 2'b01,
        DS_DONE = 2'b10
    } hpt_dev_state_t;

    typedef enum logic [1:0] {
        HS_IDLE   = 2'b00,
        HS_SETUP  = 2'b01,
        HS_STROBE = 2'b10,
        HS_END    = 2'b11
    } hpt_host_state_t;
endpackage

// file: src/hpt_if.sv
`timescale 1ns/10ps
interface hpt_if;
    logic        host_chip_select_n;
    logic        host_data_strobe_one_n;
    logic        host_data_strobe_two_n;
    logic        host_read_write;
    logic        byte_half_select;
    logic [1:0]  host_register_select;
    logic [15:0] host_address_bus;
    logic [15:0] hd_host_out;
    logic        hd_host_oe_n;
    logic [15:0] hd_dev_out;
    logic        hd_dev_oe_n;
    logic        host_ready_out;
    logic [15:0] hd_keep_val;
    logic        hd_keep_on;
    wire  [15:0] host_data_bus;

    // resolved level of the shared data bus
    assign host_data_bus = !hd_dev_oe_n  ? hd_dev_out  :
                           !hd_host_oe_n ? hd_host_out :
                           hd_keep_on    ? hd_keep_val : 16'h0000;

    modport dev (
        input  host_chip_select_n,
        input  host_data_strobe_one_n,
        input  host_data_strobe_two_n,
        input  host_read_write,
        input  byte_half_select,
        input  host_register_select,
        input  host_address_bus,
        input  host_data_bus,
        input  hd_host_oe_n,
        output hd_dev_out,
        output hd_dev_oe_n,
        output host_ready_out,
        output hd_keep_val,
        output hd_keep_on
    );

    modport host (
        output host_chip_select_n,
        output host_data_strobe_one_n,
        output host_data_strobe_two_n,
        output host_read_write,
        output byte_half_select,
        output host_register_select,
        output host_address_bus,
        output hd_host_out,
        output hd_host_oe_n,
        input  host_data_bus,
        input  host_ready_out
    );
endinterface

// file: src/hpt_host.sv
`timescale 1ns/10ps
module hpt_host (
    // clock and reset
    input  wire logic                         mclk_i,
    input  wire logic                         nrst_i,
    // host pins
    hpt_if.host                               hp,
    // command side
    input  wire logic                         host_wide_i,
    input  wire logic                         cmd_valid_i,
    input  wire logic                         cmd_write_i,
    input  wire logic [1:0]                   cmd_sel_i,
    input  wire logic [hpt_pkg::DATA_W-1:0]   cmd_addr_i,
    input  wire logic [hpt_pkg::DATA_W-1:0]   cmd_wdata_i,
    output logic                              cmd_ready_o,
    output logic                              rsp_valid_o,
    output logic [hpt_pkg::DATA_W-1:0]        rsp_rdata_o
);
    // ========================================
    // ready synchroniser
    logic r1_ff;
    logic r2_ff;
    logic r3_ff;
    logic rdy_ff;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r1_ff  <= 1'b0;
            r2_ff  <= 1'b0;
            r3_ff  <= 1'b0;
            rdy_ff <= 1'b0;
        end else begin
            r1_ff <= hp.host_ready_out;
            r2_ff <= r1_ff;
            r3_ff <= r2_ff;
            if (r2_ff == r3_ff) begin
                rdy_ff <= r3_ff;
            end
        end
    end

    // ========================================
    // access sequencer
    hpt_pkg::hpt_host_state_t st_ff;
    hpt_pkg::hpt_host_state_t nxt_st;
    logic        wr_ff;
    logic        wide_ff;
    logic        lo_ff;
    logic [1:0]  sel_ff;
    logic [15:0] addr_ff;
    logic [15:0] wdat_ff;
    logic [15:0] rdat_ff;
    logic        vld_ff;
    logic        last;

    assign last = wide_ff || lo_ff;

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            hpt_pkg::HS_IDLE: begin
                if (cmd_valid_i) begin
                    nxt_st = hpt_pkg::HS_SETUP;
                end
            end
            hpt_pkg::HS_SETUP: nxt_st = hpt_pkg::HS_STROBE;
            hpt_pkg::HS_STROBE: begin
                if (rdy_ff) begin
                    nxt_st = hpt_pkg::HS_END;
                end
            end
            hpt_pkg::HS_END: begin
                if (!rdy_ff) begin
                    nxt_st = last ? hpt_pkg::HS_IDLE : hpt_pkg::HS_SETUP;
                end
            end
            default: nxt_st = hpt_pkg::HS_IDLE;
        endcase
    end

    // reset is shared, so no access starts while it is held
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff   <= hpt_pkg::HS_IDLE;
            wr_ff   <= 1'b0;
            wide_ff <= 1'b0;
            lo_ff   <= hpt_pkg::HALF_HIGH;
            sel_ff  <= hpt_pkg::SEL_CTRL;
            addr_ff <= hpt_pkg::WORD_ZERO;
            wdat_ff <= hpt_pkg::WORD_ZERO;
            rdat_ff <= hpt_pkg::WORD_ZERO;
            vld_ff  <= 1'b0;
        end else begin
            st_ff  <= nxt_st;
            vld_ff <= 1'b0;
            if (st_ff == hpt_pkg::HS_IDLE && cmd_valid_i) begin
                wr_ff   <= cmd_write_i;
                wide_ff <= host_wide_i;
                lo_ff   <= hpt_pkg::HALF_HIGH;
                sel_ff  <= cmd_sel_i;
                addr_ff <= cmd_addr_i;
                wdat_ff <= cmd_wdata_i;
            end
            if (st_ff == hpt_pkg::HS_STROBE && rdy_ff && !wr_ff) begin
                if (wide_ff) begin
                    rdat_ff <= hp.host_data_bus;
                end else if (lo_ff) begin
                    rdat_ff[7:0] <= hp.host_data_bus[7:0];
                end else begin
                    rdat_ff[15:8] <= hp.host_data_bus[7:0];
                end
            end
            if (st_ff == hpt_pkg::HS_END && !rdy_ff) begin
                if (last) begin
                    vld_ff <= 1'b1;
                end else begin
                    lo_ff <= hpt_pkg::HALF_LOW;
                end
            end
        end
    end

    // ========================================
    // pin drive
    logic strobe;

    assign strobe = st_ff == hpt_pkg::HS_STROBE;

    assign hp.host_chip_select_n     = !strobe;
    assign hp.host_data_strobe_one_n = !strobe;
    assign hp.host_data_strobe_two_n = !strobe;
    assign hp.host_read_write        = !wr_ff || st_ff == hpt_pkg::HS_IDLE;
    assign hp.byte_half_select       = lo_ff;
    assign hp.host_register_select   = sel_ff;
    assign hp.host_address_bus       = addr_ff;
    assign hp.hd_host_out            = wide_ff ? wdat_ff
                                     : {8'h00, lo_ff ? wdat_ff[7:0]
                                                     : wdat_ff[15:8]};
    assign hp.hd_host_oe_n           = !(wr_ff
                                         && st_ff != hpt_pkg::HS_IDLE);

    assign cmd_ready_o = st_ff == hpt_pkg::HS_IDLE;
    assign rsp_valid_o = vld_ff;
    assign rsp_rdata_o = rdat_ff;
endmodule

// file: verification/hpt_props.sv
`timescale 1ns/10ps
module hpt_props (
    // clock and reset
    input wire logic        mclk_i,
    input wire logic        nrst_i,
    // watched pins
    input wire logic        host_chip_select_n,
    input wire logic        host_data_strobe_one_n,
    input wire logic        host_data_strobe_two_n,
    input wire logic        host_read_write,
    input wire logic [15:0] host_address_bus,
    input wire logic        hd_host_oe_n,
    input wire logic        hd_dev_oe_n,
    input wire logic        host_ready_out,
    input wire logic        hd_keep_on
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    // ========================================
    // pin protocol
    property p_rd_drive;
        !hd_dev_oe_n |-> host_read_write && hd_host_oe_n
            && !host_chip_select_n;
    endproperty
    a_rd_drive: assert property (p_rd_drive)
        else $error("device drives bus outside a read");
    property p_wr_drive;
        !hd_host_oe_n |-> !host_read_write;
    endproperty
    a_wr_drive: assert property (p_wr_drive)
        else $error("host drives bus outside a write");
    property p_strobe;
        $fell(host_chip_select_n) |-> !host_data_strobe_one_n
            && !host_data_strobe_two_n && !host_ready_out;
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("access start malformed");
    property p_hold;
        !host_chip_select_n && !$past(host_chip_select_n)
            |-> $stable(host_address_bus) && $stable(host_read_write);
    endproperty
    a_hold: assert property (p_hold)
        else $error("host pins moved during access");
    property p_ready_why;
        $rose(host_ready_out) |-> !host_chip_select_n
            && !host_data_strobe_one_n;
    endproperty
    a_ready_why: assert property (p_ready_why)
        else $error("ready without access");
    property p_ready_max;
        $fell(host_chip_select_n) |-> ##[1:60] host_ready_out;
    endproperty
    a_ready_max: assert property (p_ready_max)
        else $error("ready never came");
    property p_ready_end;
        $rose(host_chip_select_n) |-> ##[1:8] !host_ready_out;
    endproperty
    a_ready_end: assert property (p_ready_end)
        else $error("ready stuck after access");
    property p_rst;
        disable iff (1'b0) !nrst_i |-> host_chip_select_n
            && !host_ready_out && !hd_keep_on;
    endproperty
    a_rst: assert property (p_rst)
        else $error("activity during reset");
endmodule

// file: verification/tb_host_port_interface.sv
`timescale 1ns/10ps
module tb_host_port_interface;
    typedef struct packed {
        logic        chk;
        logic [15:0] val;
    } hpt_note_t;

    logic        mclk_i = '0, nrst_i = '1, host_width_strap_i = '0, st;
    logic        cmd_valid_i = '0, cmd_write_i = '0, cmd_ready_o;
    logic        rsp_valid_o, dma_req_o, dma_we_o, dma_ack_i = '0;
    logic        dsp_req_i = '0, dsp_stall_o, ctl_wr_i = '0, bank_switch_control_reg_wr_i = '0;
    logic        wide_mode_o, data_keep_on_o, addr_keep_on_o;
    logic [1:0]  cmd_sel_i = '0;
    logic [2:0]  kp;
    logic [14:0] dma_addr_o, dsp_addr_i = '0, a;
    logic [15:0] cmd_addr_i = '0, cmd_wdata_i = '0, rsp_rdata_o, dma_wdata_o;
    logic [15:0] dma_rdata_i = '0, ctl_wdata_i = '0, ctl_o, bank_switch_control_reg_wdata_i = '0;
    logic [15:0] bank_switch_control_reg_o, d, e;
    logic [15:0] mem [0:32767];
    logic [31:0] seed = 32'h99ad2c62, dseed = 32'h99ad2c62;
    hpt_note_t   notes[$];
    hpt_note_t   nt;
    int          n_mismatch = 0, n_tests = 0, n_rsp = 0;

    hpt_if bus ();
    hpt_device u_hpt_device (.hp(bus), .*);
    hpt_host u_hpt_host (.hp(bus), .host_wide_i(host_width_strap_i), .*);
    hpt_props u_hpt_props (
        .mclk_i                 (mclk_i),
        .nrst_i                 (nrst_i),
        .host_chip_select_n     (bus.host_chip_select_n),
        .host_data_strobe_one_n (bus.host_data_strobe_one_n),
        .host_data_strobe_two_n (bus.host_data_strobe_two_n),
        .host_read_write        (bus.host_read_write),
        .host_address_bus       (bus.host_address_bus),
        .hd_host_oe_n           (bus.hd_host_oe_n),
        .hd_dev_oe_n            (bus.hd_dev_oe_n),
        .host_ready_out         (bus.host_ready_out),
        .hd_keep_on             (bus.hd_keep_on)
    );
    assign kp = {bus.hd_keep_on, addr_keep_on_o, data_keep_on_o};

    always #5 mclk_i = ~mclk_i;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // ========================================
    // checking and closing
    task automatic check(input string nm, input logic [15:0] x,
                         input logic [15:0] y);
        n_tests++;
        if (y !== x) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, x, y);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ========================================
    // drivers
    task automatic cmd(input logic r, input logic [1:0] s,
                       input logic [15:0] ad, input logic [15:0] wd,
                       input logic c, input logic [15:0] ev);
        int k;
        k = n_rsp + 1;
        notes.push_back({c, ev});
        cmd_valid_i = 1'b1;
        cmd_write_i = !r;
        cmd_sel_i = s;
        cmd_addr_i = ad;
        cmd_wdata_i = wd;
        do @(posedge mclk_i); while (cmd_ready_o !== 1'b1);
        #1 cmd_valid_i = 1'b0;
        repeat (400) if (n_rsp < k) @(posedge mclk_i);
        #1;
        check("rsp_count", 16'(k), 16'(n_rsp));
    endtask

    task automatic do_reset(input logic m);
        #1 nrst_i = 1'b0;
        host_width_strap_i = m;
        repeat (3) @(posedge mclk_i);
        #1 nrst_i = 1'b1;
        repeat (6) @(posedge mclk_i);
        #1;
        check("wide", {15'h0, m}, {15'h0, wide_mode_o});
        check("bank_switch_control_reg_rst", 16'h0, bank_switch_control_reg_o);
        check("keep_rst", 16'h0, {15'h0, data_keep_on_o});
    endtask

    task automatic bank_switch_control_reg(input logic [15:0] v);
        bank_switch_control_reg_wr_i = 1'b1;
        bank_switch_control_reg_wdata_i = v;
        @(posedge mclk_i);
        #1 bank_switch_control_reg_wr_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        e = {13'h0, host_width_strap_i | v[2],
             host_width_strap_i & v[2], v[1]};
        check("bank_switch_control_reg", v & 16'h0006, bank_switch_control_reg_o);
        check("keepers", e, {13'h0, kp});
    endtask

    task automatic ctl(input logic [15:0] v);
        ctl_wr_i = 1'b1;
        ctl_wdata_i = v;
        @(posedge mclk_i);
        #1 ctl_wr_i = 1'b0;
        @(posedge mclk_i);
        #1;
    endtask

    // ========================================
    // response watcher and memory side
    always @(posedge mclk_i) begin
        if (rsp_valid_o === 1'b1 && notes.size() > 0) begin
            nt = notes.pop_front();
            n_rsp++;
            if (nt.chk) check("rsp_rdata", nt.val, rsp_rdata_o);
        end
    end

    always @(posedge mclk_i) begin
        dseed = lfsr(dseed);
        if (dma_req_o === 1'b1 && !dma_ack_i && dseed[0]) begin
            st = dsp_req_i && (dsp_addr_i == dma_addr_o);
            check("stall", {15'h0, st}, {15'h0, dsp_stall_o});
            if (dma_we_o) mem[dma_addr_o] = dma_wdata_o;
            #1 dma_ack_i = 1'b1;
            dma_rdata_i = mem[dma_addr_o];
        end else begin
            #1 dma_ack_i = 1'b0;
            dma_rdata_i = ~dma_rdata_i;
        end
    end

    // ========================================
    // scenarios
    initial begin
        for (int m = 0; m < 2; m++) begin
            do_reset(m[0]);
            seed = lfsr(seed);
            bank_switch_control_reg(seed[15:0]);
            bank_switch_control_reg(~seed[15:0]);
            if (m == 0) begin
                a = {seed[14:4], 4'h0};
                d = seed[31:16];
                e = ~seed[15:0];
                cmd(1'b0, hpt_pkg::SEL_ADDR, '0, {1'b0, a}, 1'b0, '0);
                cmd(1'b0, hpt_pkg::SEL_DATA_INC, '0, d, 1'b0, '0);
                cmd(1'b0, hpt_pkg::SEL_DATA_INC, '0, e, 1'b0, '0);
                check("mem0", d, mem[a]);
                check("mem1", e, mem[a + 15'h1]);
                cmd(1'b0, hpt_pkg::SEL_ADDR, '0, {1'b0, a}, 1'b0, '0);
                cmd(1'b1, hpt_pkg::SEL_DATA_INC, '0, '0, 1'b1, d);
                cmd(1'b1, hpt_pkg::SEL_DATA_INC, '0, '0, 1'b1, e);
                cmd(1'b1, hpt_pkg::SEL_ADDR, '0, '0, 1'b1, {1'b0, a + 15'h2});
                cmd(1'b0, hpt_pkg::SEL_ADDR, '0, {1'b0, a + 15'h1}, 1'b0, '0);
                repeat (2) cmd(1'b1, hpt_pkg::SEL_DATA, '0, '0, 1'b1, e);
                ctl(d);
                check("ctl", d, ctl_o);
                cmd(1'b1, hpt_pkg::SEL_CTRL, '0, '0, 1'b1, d);
            end else begin
                for (int k = 0; k < 6; k++) begin
                    seed = lfsr(seed);
                    a = (k == 0) ? 15'h7fff : seed[14:0];
                    d = seed[31:16];
                    dsp_req_i = 1'b1;
                    dsp_addr_i = k[0] ? a : ~a;
                    cmd(1'b0, 2'h0, {seed[15], a}, d, 1'b0, '0);
                    check("mem", d, mem[a]);
                    cmd(1'b1, 2'h0, {~seed[15], a}, '0, 1'b1, d);
                    check("held_bus", d, bus.host_data_bus);
                end
                ctl(16'h00ff);
                check("ctl_wide", 16'h0000, ctl_o);
            end
        end
        end_of_test();
    end

    initial begin
        #400000;
        n_mismatch++;
        end_of_test();
    end
endmodule
